// ---- core/dsta_alloc.sv ----
// DS0 time-slot allocator: slot tables, allocation commands and slot data path
// How it works
// R1: Keep readable entry per slot, both interfaces
// R2: Entry is free, port 1-4, or link
// R3: Block mode allocates adjacent run from start
// R4: Reject starting slot lacking enough remaining slots
// R5: Alternate mode reserves twice, data every second
// R6: Interleaved slots send ones, ignore receive
// R7: Channel mode rate follows owned slot count
// R8: Port destination: network, drop/insert, or port
// R9: Port-to-port mapping needs rate, no slot
// R10: Selectable rates follow 64 or 56 base
// R11: Block allocations released only by clear
// R12: Toggling own slot in channel mode frees
// R13: Taking another owner's slot is ignored
// R14: Block rates n times base, n to 24
// R15: Mutually mapped ports raise data-set-ready
// R16: Never overlap owners; reject overlapping allocations
`timescale 1ns/1ps
module dsta_alloc (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Data port transmit stream
	input wire logic port_tx_valid_in,
	input wire logic [1:0] port_tx_port_in,
	input wire logic [7:0] port_tx_byte_in,
	output logic port_tx_ready_out,
	// Network transmit slot strobe
	input wire logic net_tx_req_in,
	input wire logic [4:0] net_tx_slot_in,
	output logic net_tx_valid_out,
	output logic [7:0] net_tx_byte_out,
	// Network receive slot strobe
	input wire logic net_rx_valid_in,
	input wire logic [4:0] net_rx_slot_in,
	input wire logic [7:0] net_rx_byte_in,
	output logic port_rx_valid_out,
	output logic [1:0] port_rx_port_out,
	output logic [7:0] port_rx_byte_out,
	// Data-set-ready per port
	output logic [3:0] dsr_out
);
	localparam int NS = dsta_pkg::SLOTS;
	localparam int NP = dsta_pkg::PORTS;
	localparam int EW = dsta_pkg::ENT_W;

	logic [NS-1:0][EW-1:0] net_tab, next_net, di_tab, next_di, seltab, work;
	logic [NP-1:0][dsta_pkg::PCFG_W-1:0] pcfg, next_pcfg;
	logic [1:0] status, next_status;
	logic [3:0] next_dsr;
	logic [NP-1:0] mutual;
	logic [NP-1:0][5:0] port_cnt;
	logic [31:0] next_rdata;
	logic cmd_go, sel_di, alt, rate_ok, fit, busy, alloc_ok, in_run, enc_bad;
	dsta_pkg::dsta_op_e op;
	logic [1:0] cp, cdest, cmode, dest_p, dport_p;
	logic [4:0] sa, sb, crate, rd_idx;
	logic [5:0] run_len;
	logic [6:0] cfg_entry, tx_entry, rx_entry;
	logic [7:0] tab_off;
	logic f_valid, f_pop, next_tx_valid, next_prx_valid;
	logic [9:0] f_data;
	logic [7:0] next_tx_byte, next_prx_byte;
	logic [1:0] next_prx_port;
	logic [11:0] rate_kbps;

	// Command decode
	assign cmd_go = reg_wr_in && (reg_addr_in == dsta_pkg::REG_CMD);
	assign op = dsta_pkg::dsta_op_e'(reg_wdata_in[dsta_pkg::CMD_OP_LSB +: 3]);
	assign cp = reg_wdata_in[dsta_pkg::CMD_PORT_LSB +: 2];
	assign sa = reg_wdata_in[dsta_pkg::CMD_SLOTA_LSB +: 5];
	assign sb = reg_wdata_in[dsta_pkg::CMD_SLOTB_LSB +: 5];
	// R8: destination select
	assign cdest = pcfg[cp][dsta_pkg::PCFG_DEST_LSB +: 2];
	assign cmode = pcfg[cp][dsta_pkg::PCFG_MODE_LSB +: 2];
	assign crate = pcfg[cp][dsta_pkg::PCFG_RATE_LSB +: 5];
	assign sel_di = (cdest == dsta_pkg::DSTA_DEST_DROPINSERT);
	assign seltab = sel_di ? di_tab : net_tab;
	assign alt = (cmode == dsta_pkg::DSTA_MODE_ALTERNATE_IDLE_BLOCK);

	// Allocation check and the selected table as it would become
	always_comb begin
		// R5: alternate run is twice the rate count
		run_len = alt ? {crate, 1'b0} : {1'b0, crate};
		// R14: rate count bounded per mode
		rate_ok = (crate != 5'h00) && (crate <= (alt ? dsta_pkg::ALT_MAX_N : dsta_pkg::BLOCK_MAX_N));
		// R4: run must end inside the frame
		fit = rate_ok && (({1'b0, sa} + run_len) <= dsta_pkg::SLOT_CNT);
		busy = 1'b0;
		in_run = 1'b0;
		work = seltab;
		cfg_entry = {dsta_pkg::KIND_OWNED_BY_DATA_PORT, 3'h0, cp};
		for (int i = 0; i < NS; i++) begin
			in_run = (6'(i) >= {1'b0, sa}) && (6'(i) < ({1'b0, sa} + run_len));
			// R16: any owned slot in the run blocks it
			if (in_run && (seltab[i][EW-1 -: 2] != dsta_pkg::KIND_FREE)) begin
				busy = 1'b1;
			end
			// R3: adjacent run from start; R6: in alternate mode odd offsets send ones
			if (in_run) begin
				work[i] = (alt && ((5'(i) - sa) & 5'h01) != 5'h00) ?
					{dsta_pkg::KIND_IDLE_ONES, 3'h0, cp} : cfg_entry;
			end
		end
		alloc_ok = 1'b0;
		if (cdest == dsta_pkg::DSTA_DEST_PORT) begin
			// R9: port mapping holds no slots
			alloc_ok = 1'b0;
		end else if (cmode == dsta_pkg::DSTA_MODE_CHAN) begin
			work = seltab;
			if ({1'b0, sa} < dsta_pkg::SLOT_CNT) begin
				if (seltab[sa][EW-1 -: 2] == dsta_pkg::KIND_FREE) begin
					work[sa] = cfg_entry;
					alloc_ok = 1'b1;
				// R12: own slot returns to free
				end else if (seltab[sa] == cfg_entry) begin
					work[sa] = dsta_pkg::ENTRY_RST;
					alloc_ok = 1'b1;
				end
				// R13: other owner leaves alloc_ok low
			end
		end else begin
			alloc_ok = fit && !busy;
		end
	end

	// Slot tables and command status
	always_comb begin
		next_net = net_tab;
		next_di = di_tab;
		next_status = status;
		if (cmd_go) begin
			next_status = 2'h2;
			case (op)
				dsta_pkg::DSTA_OP_ALLOC: begin
					if (alloc_ok) begin
						next_status = 2'h1;
						if (sel_di) begin
							next_di = work;
						end else begin
							next_net = work;
						end
					end
				end
				// R11: clear is the only release of a block
				dsta_pkg::DSTA_OP_CLR_PORT: begin
					next_status = 2'h1;
					for (int i = 0; i < NS; i++) begin
						if (net_tab[i][EW-1] == 1'b0 && net_tab[i][EW-2] && net_tab[i][1:0] == cp
							|| net_tab[i][EW-1 -: 2] == dsta_pkg::KIND_IDLE_ONES && net_tab[i][1:0] == cp) begin
							next_net[i] = dsta_pkg::ENTRY_RST;
						end
						if (di_tab[i][EW-1 -: 2] != dsta_pkg::KIND_FREE
							&& di_tab[i][EW-1 -: 2] != dsta_pkg::KIND_SLOT_LINK && di_tab[i][1:0] == cp) begin
							next_di[i] = dsta_pkg::ENTRY_RST;
						end
					end
				end
				dsta_pkg::DSTA_OP_CLR_IFACE: begin
					next_status = 2'h1;
					// Links span both tables, so their far halves go too
					for (int i = 0; i < NS; i++) begin
						if (reg_wdata_in[dsta_pkg::CMD_IFACE_BIT]) begin
							next_di[i] = dsta_pkg::ENTRY_RST;
							if (net_tab[i][EW-1 -: 2] == dsta_pkg::KIND_SLOT_LINK) begin
								next_net[i] = dsta_pkg::ENTRY_RST;
							end
						end else begin
							next_net[i] = dsta_pkg::ENTRY_RST;
							if (di_tab[i][EW-1 -: 2] == dsta_pkg::KIND_SLOT_LINK) begin
								next_di[i] = dsta_pkg::ENTRY_RST;
							end
						end
					end
				end
				// R16: cross-connect only between two free slots
				dsta_pkg::DSTA_OP_XCONN: begin
					if ({1'b0, sa} < dsta_pkg::SLOT_CNT && {1'b0, sb} < dsta_pkg::SLOT_CNT
						&& net_tab[sa][EW-1 -: 2] == dsta_pkg::KIND_FREE
						&& di_tab[sb][EW-1 -: 2] == dsta_pkg::KIND_FREE) begin
						next_status = 2'h1;
						next_net[sa] = {dsta_pkg::KIND_SLOT_LINK, sb};
						next_di[sb] = {dsta_pkg::KIND_SLOT_LINK, sa};
					end
				end
				default: begin
					next_status = status;
				end
			endcase
		end
	end

	// Port configuration, data-set-ready and per-port slot counts
	always_comb begin
		next_pcfg = pcfg;
		if (reg_wr_in && reg_addr_in[7:4] == dsta_pkg::REG_PCFG_PAGE) begin
			next_pcfg[reg_addr_in[3:2]] = reg_wdata_in[dsta_pkg::PCFG_W-1:0];
		end
		for (int p = 0; p < NP; p++) begin
			dest_p = pcfg[p][dsta_pkg::PCFG_DEST_LSB +: 2];
			dport_p = pcfg[p][dsta_pkg::PCFG_DPORT_LSB +: 2];
			// R15: both ends point at each other
			mutual[p] = (dest_p == dsta_pkg::DSTA_DEST_PORT) && (dport_p != 2'(p))
				&& (pcfg[dport_p][dsta_pkg::PCFG_DEST_LSB +: 2] == dsta_pkg::DSTA_DEST_PORT)
				&& (pcfg[dport_p][dsta_pkg::PCFG_DPORT_LSB +: 2] == 2'(p));
			port_cnt[p] = 6'h00;
			// R7: rate follows count of data slots
			for (int i = 0; i < NS; i++) begin
				port_cnt[p] = port_cnt[p]
					+ 6'(net_tab[i] == {dsta_pkg::KIND_OWNED_BY_DATA_PORT, 3'h0, 2'(p)})
					+ 6'(di_tab[i] == {dsta_pkg::KIND_OWNED_BY_DATA_PORT, 3'h0, 2'(p)});
			end
		end
		next_dsr = mutual;
	end

	// Register read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		tab_off = 8'h00;
		rd_idx = 5'h00;
		rate_kbps = 12'h000;
		if (reg_rd_in) begin
			if (reg_addr_in == dsta_pkg::REG_STATUS) begin
				next_rdata = {24'h00_0000, dsr_out, 2'h0, status};
			end else if (reg_addr_in[7:4] == dsta_pkg::REG_PCFG_PAGE) begin
				next_rdata = 32'(pcfg[reg_addr_in[3:2]]);
			end else if (reg_addr_in[7:4] == dsta_pkg::REG_PSTAT_PAGE) begin
				// R10: rate scales by the configured base
				rate_kbps = ((pcfg[reg_addr_in[3:2]][dsta_pkg::PCFG_DEST_LSB +: 2]
					== dsta_pkg::DSTA_DEST_PORT) ?
					12'(pcfg[reg_addr_in[3:2]][dsta_pkg::PCFG_RATE_LSB +: 5]) :
					12'(port_cnt[reg_addr_in[3:2]]))
					* (pcfg[reg_addr_in[3:2]][dsta_pkg::PCFG_BASE_BIT] ?
					dsta_pkg::KBPS_FIFTYSIX : dsta_pkg::KBPS_SIXTYFOUR);
				next_rdata = {4'h0, rate_kbps, 10'h000, port_cnt[reg_addr_in[3:2]]};
			// R1: both tables readable per slot
			end else if (reg_addr_in >= dsta_pkg::REG_NET_BASE
				&& reg_addr_in < dsta_pkg::REG_DI_BASE) begin
				tab_off = reg_addr_in - dsta_pkg::REG_NET_BASE;
				rd_idx = tab_off[6:2];
				next_rdata = 32'(net_tab[rd_idx]);
			end else if (reg_addr_in >= dsta_pkg::REG_DI_BASE) begin
				tab_off = reg_addr_in - dsta_pkg::REG_DI_BASE;
				rd_idx = tab_off[6:2];
				next_rdata = (tab_off < dsta_pkg::REG_TAB_SPAN) ? 32'(di_tab[rd_idx]) : 32'h0;
			end
		end
	end

	// Queued port bytes; a head byte for a port with no slot due waits
	dsta_fifo #(
		.W(dsta_pkg::FIFO_W),
		.D(dsta_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.in_valid_in(port_tx_valid_in),
		.in_data_in({port_tx_port_in, port_tx_byte_in}),
		.in_ready_out(port_tx_ready_out),
		.out_valid_out(f_valid),
		.out_data_out(f_data),
		.out_ready_in(f_pop)
	);

	// Slot data path
	always_comb begin
		tx_entry = ({1'b0, net_tx_slot_in} < dsta_pkg::SLOT_CNT) ?
			net_tab[net_tx_slot_in] : dsta_pkg::ENTRY_RST;
		rx_entry = ({1'b0, net_rx_slot_in} < dsta_pkg::SLOT_CNT) ?
			net_tab[net_rx_slot_in] : dsta_pkg::ENTRY_RST;
		f_pop = net_tx_req_in && f_valid && (f_data[9:8] == tx_entry[1:0])
			&& (tx_entry[EW-1 -: 2] == dsta_pkg::KIND_OWNED_BY_DATA_PORT);
		next_tx_valid = net_tx_req_in;
		// R6: idle, free and underrun slots send all ones
		next_tx_byte = f_pop ? f_data[7:0] : dsta_pkg::TX_IDLE_BYTE;
		// R6: received idle slots are dropped
		next_prx_valid = net_rx_valid_in
			&& (rx_entry[EW-1 -: 2] == dsta_pkg::KIND_OWNED_BY_DATA_PORT);
		next_prx_port = rx_entry[1:0];
		next_prx_byte = net_rx_byte_in;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			net_tab <= '0;
			di_tab <= '0;
			pcfg <= '0;
			status <= 2'h0;
			dsr_out <= 4'h0;
			reg_rdata_out <= 32'h0000_0000;
			net_tx_valid_out <= 1'b0;
			net_tx_byte_out <= dsta_pkg::TX_IDLE_BYTE;
			port_rx_valid_out <= 1'b0;
			port_rx_port_out <= 2'h0;
			port_rx_byte_out <= 8'h00;
		end else begin
			net_tab <= next_net;
			di_tab <= next_di;
			pcfg <= next_pcfg;
			status <= next_status;
			dsr_out <= next_dsr;
			reg_rdata_out <= next_rdata;
			net_tx_valid_out <= next_tx_valid;
			net_tx_byte_out <= next_tx_byte;
			port_rx_valid_out <= next_prx_valid;
			port_rx_port_out <= next_prx_port;
			port_rx_byte_out <= next_prx_byte;
		end
	end

	// Checks
	always_comb begin
		enc_bad = 1'b0;
		for (int i = 0; i < NS; i++) begin
			if (net_tab[i][EW-1 -: 2] == dsta_pkg::KIND_SLOT_LINK
				&& {1'b0, net_tab[i][4:0]} >= dsta_pkg::SLOT_CNT) begin
				enc_bad = 1'b1;
			end
			if (net_tab[i][EW-1] == 1'b0 && net_tab[i][4:2] != 3'h0) begin
				enc_bad = 1'b1;
			end
		end
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	// R1: slot read
	slot_read_a: assert property ( // R1
		reg_rd_in && reg_addr_in == dsta_pkg::REG_NET_BASE && !cmd_go
		|=> reg_rdata_out == 32'(net_tab[0]) ##1 reg_rdata_out == 32'h0 || $past(reg_rd_in))
		else $error("slot entry read wrong");
	// R2: entry encoding
	entry_code_a: assert property (!enc_bad) // R2
		else $error("bad slot entry code");
	// R3: block run start
	block_run_a: assert property ( // R3
		cmd_go && op == dsta_pkg::DSTA_OP_ALLOC && alloc_ok && !sel_di
		&& cmode == dsta_pkg::DSTA_MODE_BLOCK
		|=> net_tab[$past(sa)] == {dsta_pkg::KIND_OWNED_BY_DATA_PORT, 3'h0, $past(cp)})
		else $error("block start slot not owned");
	// R4: short start rejected
	fit_reject_a: assert property ( // R4
		cmd_go && op == dsta_pkg::DSTA_OP_ALLOC && cmode != dsta_pkg::DSTA_MODE_CHAN && !fit
		|=> status == 2'h2 && net_tab == $past(net_tab) && di_tab == $past(di_tab))
		else $error("unfit start accepted");
	// R5: alternate idle slot
	alt_idle_a: assert property ( // R5
		cmd_go && op == dsta_pkg::DSTA_OP_ALLOC && alloc_ok && alt && !sel_di
		|=> net_tab[5'($past(sa) + 5'h01)][EW-1 -: 2] == dsta_pkg::KIND_IDLE_ONES)
		else $error("alternate slot not idle");
	// R6: idle slot sends ones
	tx_ones_a: assert property ( // R6
		net_tx_req_in && tx_entry[EW-1 -: 2] == dsta_pkg::KIND_IDLE_ONES
		|=> net_tx_valid_out && net_tx_byte_out == dsta_pkg::TX_IDLE_BYTE)
		else $error("idle slot carried data");
	// R13: foreign slot kept
	other_owner_a: assert property ( // R13
		cmd_go && op == dsta_pkg::DSTA_OP_ALLOC && cmode == dsta_pkg::DSTA_MODE_CHAN && !sel_di
		&& net_tab[sa][EW-1 -: 2] == dsta_pkg::KIND_OWNED_BY_DATA_PORT && net_tab[sa][1:0] != cp
		|=> net_tab == $past(net_tab) ##1 status == 2'h2 || $past(cmd_go))
		else $error("foreign slot taken");
	// R15: data-set-ready pairs
	dsr_pair_a: assert property ( // R15
		dsr_out[0] |-> dsr_out[$past(pcfg[0][dsta_pkg::PCFG_DPORT_LSB +: 2])])
		else $error("data-set-ready not paired");

	block_ok_c: cover property (cmd_go && op == dsta_pkg::DSTA_OP_ALLOC && alloc_ok && !alt);
	alt_ok_c: cover property (cmd_go && op == dsta_pkg::DSTA_OP_ALLOC && alloc_ok && alt);
	dsr_rise_c: cover property ($rose(dsr_out[0]));
	tx_data_c: cover property (f_pop);
endmodule

// ---- common/dsta_pkg.sv ----
// Constants and types shared by the DS0 time-slot allocator
package dsta_pkg;
	localparam int SLOTS = 24;
	localparam int PORTS = 4;
	localparam int ENT_W = 7;
	localparam int PCFG_W = 13;
	localparam int FIFO_W = 10;
	localparam int FIFO_DEPTH = 8;
	localparam logic [5:0] SLOT_CNT = 6'h18;
	localparam logic [4:0] BLOCK_MAX_N = 5'h18;
	localparam logic [4:0] ALT_MAX_N = 5'h0c;

	// Slot entry: {kind, value}; value is a port number or a far-side slot
	localparam logic [1:0] KIND_FREE = 2'h0;
	localparam logic [1:0] KIND_OWNED_BY_DATA_PORT = 2'h1;
	// In the network table this is a dropinsert_slot_link, and vice versa
	localparam logic [1:0] KIND_SLOT_LINK = 2'h2;
	localparam logic [1:0] KIND_IDLE_ONES = 2'h3;
	localparam logic [6:0] ENTRY_RST = 7'h00;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [3:0] REG_PCFG_PAGE = 4'h1;
	localparam logic [3:0] REG_PSTAT_PAGE = 4'h2;
	localparam logic [7:0] REG_NET_BASE = 8'h40;
	localparam logic [7:0] REG_DI_BASE = 8'ha0;
	localparam logic [7:0] REG_TAB_SPAN = 8'h60;

	// Command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_PORT_LSB = 4;
	localparam int CMD_IFACE_BIT = 8;
	localparam int CMD_SLOTA_LSB = 10;
	localparam int CMD_SLOTB_LSB = 16;

	// Port configuration fields
	localparam int PCFG_DEST_LSB = 0;
	localparam int PCFG_DPORT_LSB = 2;
	localparam int PCFG_MODE_LSB = 4;
	localparam int PCFG_BASE_BIT = 6;
	localparam int PCFG_RATE_LSB = 8;
	localparam logic [12:0] PCFG_RST = 13'h0000;
	localparam int PSTAT_RATE_LSB = 16;

	localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
	localparam logic base_rate_sixtyfour = 1'b0;
	localparam logic base_rate_fiftysix = 1'b1;
	localparam logic [11:0] KBPS_SIXTYFOUR = 12'h040;
	localparam logic [11:0] KBPS_FIFTYSIX = 12'h038;

	typedef enum logic [2:0] {
		DSTA_OP_NONE = 3'h0,
		DSTA_OP_ALLOC = 3'h1,
		DSTA_OP_CLR_PORT = 3'h2,
		DSTA_OP_CLR_IFACE = 3'h3,
		DSTA_OP_XCONN = 3'h4
	} dsta_op_e;

	typedef enum logic [1:0] {
		DSTA_MODE_BLOCK = 2'h0,
		DSTA_MODE_ALTERNATE_IDLE_BLOCK = 2'h1,
		DSTA_MODE_CHAN = 2'h2
	} dsta_mode_e;

	typedef enum logic [1:0] {
		DSTA_DEST_NETWORK_SIDE = 2'h0,
		DSTA_DEST_DROPINSERT = 2'h1,
		DSTA_DEST_PORT = 2'h2
	} dsta_dest_e;
endpackage

// ---- core/dsta_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dsta_fifo #(
	parameter int W = 10,
	parameter int D = 8
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Fill side
	input wire logic in_valid_in,
	input wire logic [W-1:0] in_data_in,
	output logic in_ready_out,
	// Drain side
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	assign in_ready_out = (count != (AW+1)'(D));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		next_wr_ptr = push ? ((wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? ((rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage has no reset; only occupied words are ever read
	always_ff @(posedge sys_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	fifo_bound_a: assert property (count <= (AW+1)'(D))
		else $error("fifo count above depth");
	fifo_full_a: assert property (!in_ready_out |=> count == (AW+1)'(D) || $past(pop))
		else $error("fifo full flag wrong");
endmodule

// ---- verif/dsta_line_model.sv ----
// Behavioural T1 line model: one slot strobe every four cycles, both directions
`timescale 1ns/1ps
module dsta_line_model (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Control from the bench
	input wire logic run_in,
	// Slot strobes toward the allocator
	output logic req_out,
	output logic [4:0] slot_out,
	output logic rx_valid_out,
	output logic [7:0] rx_byte_out
);
	logic [1:0] phase;
	logic [4:0] cur;
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			phase <= 2'h0;
			cur <= 5'h00;
			req_out <= 1'b0;
			rx_valid_out <= 1'b0;
			slot_out <= 5'h1f;
			rx_byte_out <= 8'h00;
		end else begin
			phase <= phase + 2'h1;
			req_out <= run_in && phase == 2'h0;
			rx_valid_out <= run_in && phase == 2'h0;
			if (run_in && phase == 2'h0) begin
				slot_out <= cur;
				rx_byte_out <= 8'ha0 | {3'h0, cur};
				cur <= (cur == 5'h17) ? 5'h00 : cur + 5'h01;
			end else begin
				// Slot number and byte change between strobes so stale values never look valid
				slot_out <= ~slot_out;
				rx_byte_out <= ~rx_byte_out;
			end
		end
	end
endmodule

// ---- verif/dsta_alloc_bench.sv ----
// Self-checking bench for the DS0 time-slot allocator
`timescale 1ns/1ps
`define CHK(nm, e, g) check_eq(nm, 32'(e), 32'(g))
module dsta_alloc_bench;
	typedef struct {
		logic [7:0] pa;
		logic [31:0] pv;
		logic [31:0] cmd;
		logic [1:0] st;
		logic [7:0] qa;
		logic [31:0] qv;
	} dsta_row_s;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] rdata;
	logic tx_valid = 1'b0;
	logic [1:0] tx_port = 2'h0;
	logic [7:0] tx_byte = 8'h00;
	logic tx_ready, req, rx_v, net_tx_valid, prx_v;
	logic [4:0] slot, req_slot;
	logic [7:0] rx_byte, net_tx_byte, prx_byte, last4;
	logic [1:0] prx_port;
	logic [3:0] dsr;
	logic run = 1'b0;
	logic bad, rx4, rx9, ok;
	logic [31:0] d;
	int pops, acc;
	int err_count = 0;
	int check_count = 0;
	dsta_row_s rows [17];

	always #2 sys_clk_in = ~sys_clk_in;

	dsta_alloc dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
		.port_tx_valid_in(tx_valid), .port_tx_port_in(tx_port), .port_tx_byte_in(tx_byte),
		.port_tx_ready_out(tx_ready), .net_tx_req_in(req), .net_tx_slot_in(slot),
		.net_tx_valid_out(net_tx_valid), .net_tx_byte_out(net_tx_byte), .net_rx_valid_in(rx_v),
		.net_rx_slot_in(slot), .net_rx_byte_in(rx_byte), .port_rx_valid_out(prx_v),
		.port_rx_port_out(prx_port), .port_rx_byte_out(prx_byte), .dsr_out(dsr));

	dsta_line_model line (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .run_in(run),
		.req_out(req), .slot_out(slot), .rx_valid_out(rx_v), .rx_byte_out(rx_byte));

	// Slot data monitor, live only while the line runs
	always @(posedge sys_clk_in) begin
		if (req) begin
			req_slot <= slot;
		end
		if (net_tx_valid && req_slot == 5'h04 && net_tx_byte != 8'hff) begin
			pops++;
			last4 = net_tx_byte;
		end
		if (net_tx_valid && (req_slot == 5'h05 || req_slot == 5'h09) && net_tx_byte !== 8'hff) begin
			bad = 1'b1;
		end
		if (prx_v && prx_byte == 8'ha5) begin
			bad = 1'b1;
		end
		if (prx_v && prx_byte == 8'ha4 && prx_port == 2'h0) begin
			rx4 = 1'b1;
		end
		if (prx_v && prx_byte == 8'ha9 && prx_port == 2'h3) begin
			rx9 = 1'b1;
		end
	end

	task automatic check_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd <= 1'b0;
		#1 v = rdata;
	endtask

	// Offer one byte; give up after three edges without ready
	task automatic push(input logic [1:0] p, input logic [7:0] b, output logic took);
		@(posedge sys_clk_in);
		tx_valid <= 1'b1;
		tx_port <= p;
		tx_byte <= b;
		took = 1'b0;
		for (int i = 0; i < 3 && !took; i++) begin
			@(posedge sys_clk_in);
			took = (tx_ready === 1'b1);
		end
		tx_valid <= 1'b0;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#80000;
		err_count++;
		close_out();
	end

	initial begin
		rows = '{
			'{8'h10, 32'h0300, 32'h00001, 2'h1, 8'h48, 32'h20},
			'{8'h14, 32'h0200, 32'h05811, 2'h1, 8'h9c, 32'h21},
			'{8'h18, 32'h0300, 32'h05821, 2'h2, 8'h98, 32'h21},
			'{8'h18, 32'h0210, 32'h01021, 2'h1, 8'h54, 32'h62},
			'{8'h1c, 32'h0020, 32'h01831, 2'h2, 8'h58, 32'h22},
			'{8'hfc, 32'hffff, 32'h02831, 2'h1, 8'h68, 32'h23},
			'{8'hfc, 32'hffff, 32'h02831, 2'h1, 8'h68, 32'h00},
			'{8'hfc, 32'hffff, 32'h03031, 2'h1, 8'h2c, 32'h00400001},
			'{8'h10, 32'h0306, 32'h00001, 2'h2, 8'h40, 32'h20},
			'{8'hfc, 32'hffff, 32'h00103, 2'h1, 8'h40, 32'h20},
			'{8'h1c, 32'h0021, 32'h00c31, 2'h1, 8'hac, 32'h23},
			'{8'hfc, 32'hffff, 32'h53c04, 2'h1, 8'h7c, 32'h45},
			'{8'hfc, 32'hffff, 32'h03c11, 2'h2, 8'hb4, 32'h4f},
			'{8'hfc, 32'hffff, 32'h00022, 2'h1, 8'h54, 32'h00},
			'{8'hfc, 32'hffff, 32'h00003, 2'h1, 8'h40, 32'h00},
			'{8'h18, 32'h1840, 32'h00021, 2'h1, 8'h28, 32'h05400018},
			'{8'h14, 32'h0d10, 32'h00011, 2'h2, 8'hac, 32'h23}};
		repeat (10) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].pa, rows[i].pv);
			wr(dsta_pkg::REG_CMD, rows[i].cmd);
			rd(dsta_pkg::REG_STATUS, d);
			`CHK("status", rows[i].st, d[1:0]);
			rd(rows[i].qa, d);
			`CHK("entry", rows[i].qv, d);
			$display("row %0d done", i);
		end
		// Port 1 maps to a port: rate from n and base alone, no slots held
		rd(8'h20, d);
		`CHK("port map rate", 32'h00c00000, d);
		$display("port map test done");
		// Mid-run reset returns every table and setting to its start value
		@(posedge sys_clk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		rd(8'h40, d);
		`CHK("slot after reset", 32'h0, d);
		rd(8'h18, d);
		`CHK("config after reset", 32'h0, d);
		rd(8'h3c, d);
		`CHK("unmapped read", 32'h0, d);
		$display("reset test done");
		// Alternate block on slots 4-5, channel slot 9 for port 4; FIFO filled with line idle
		wr(8'h10, 32'h0110);
		wr(dsta_pkg::REG_CMD, 32'h1001);
		wr(8'h1c, 32'h0020);
		wr(dsta_pkg::REG_CMD, 32'h2431);
		acc = 0;
		for (int i = 0; i < 9; i++) begin
			push(2'h0, 8'h30 + 8'(i), ok);
			acc += int'(ok);
		end
		`CHK("bytes taken", dsta_pkg::FIFO_DEPTH, acc);
		pops = 0;
		bad = 1'b0;
		rx4 = 1'b0;
		rx9 = 1'b0;
		run <= 1'b1;
		repeat (1200) @(posedge sys_clk_in);
		run <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		`CHK("slot 4 pops", 8, pops);
		`CHK("slot 4 last byte", 8'h37, last4);
		`CHK("idle slot traffic", 1'b0, bad);
		`CHK("slot 4 receive", 1'b1, rx4);
		`CHK("slot 9 receive", 1'b1, rx9);
		`CHK("ready after drain", 1'b1, tx_ready);
		$display("data path test done");
		// Ports 1 and 2 mapped to each other raise data-set-ready on both
		wr(8'h10, 32'h0006);
		repeat (3) @(posedge sys_clk_in);
		`CHK("dsr one sided", 4'h0, dsr);
		wr(8'h14, 32'h0002);
		repeat (3) @(posedge sys_clk_in);
		`CHK("dsr mutual", 4'h3, dsr);
		rd(dsta_pkg::REG_STATUS, d);
		`CHK("status dsr", 4'h3, d[7:4]);
		$display("dsr test done");
		close_out();
	end
endmodule
